// [logic/spt_param_table.sv]
/*
 * spt_param_table: read-only parameter database of the serial flash,
 * presented as a byte stream to the serial front end and as words
 * over an AXI4-Lite slave, plus the erase-opcode decode.
 * Assumes the serial front end runs on aclk and gives one-cycle
 * start/next/stop strobes; the AXI master follows AXI4-Lite.
 */
`default_nettype none
module spt_param_table (
	input  wire logic        aclk,
	input  wire logic        aclk_en,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rd_start,
	input  wire logic [23:0] rd_addr,
	input  wire logic        rd_next,
	input  wire logic        rd_stop,
	output logic [7:0]       rd_byte,
	output logic [23:0]      rd_byte_addr,
	output logic             rd_byte_valid,
	input  wire logic        op_valid,
	input  wire logic [7:0]  op_code,
	output logic             erase_valid,
	output logic [1:0]       erase_kind
);

	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [31:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic        w_strb0_r;
	logic [2:0]  den_sel_r;
	logic        opt_c_r;
	logic [7:0]  byte_r;
	logic [23:0] baddr_r;
	logic        bvld_r;
	logic        er_vld_r;
	logic [1:0]  er_kind_r;

	// one database byte; holes and anything past the table read FFh
	function automatic logic [7:0] byte_at(input logic [23:0] a, input logic [7:0] den);
		logic [7:0] v;
		v = spt_pkg::V_FILL;
		if (a[23:8] == 16'h0000) begin
			unique case (a[7:0])
				spt_pkg::A_SIG0:  v = spt_pkg::V_SIG0;
				spt_pkg::A_SIG1:  v = spt_pkg::V_SIG1;
				spt_pkg::A_SIG2:  v = spt_pkg::V_SIG2;
				spt_pkg::A_SIG3:  v = spt_pkg::V_SIG3;
				spt_pkg::A_REVMN: v = spt_pkg::V_MINOR;
				spt_pkg::A_REVMJ: v = spt_pkg::V_MAJOR;
				spt_pkg::A_HCNT:  v = spt_pkg::V_HCNT;
				spt_pkg::A_UNUSD: v = spt_pkg::V_FILL;
				spt_pkg::A_IDLO:  v = spt_pkg::V_IDLO;
				spt_pkg::A_PMNR:  v = spt_pkg::V_MINOR;
				spt_pkg::A_PMJR:  v = spt_pkg::V_MAJOR;
				spt_pkg::A_PLEN:  v = spt_pkg::V_PLEN;
				spt_pkg::A_PTR0:  v = spt_pkg::V_PTR0;
				spt_pkg::A_PTR1:  v = spt_pkg::V_PTR1;
				spt_pkg::A_PTR2:  v = spt_pkg::V_PTR2;
				spt_pkg::A_IDHI:  v = spt_pkg::V_IDHI;
				spt_pkg::A_ERSZ:  v = spt_pkg::V_ERSZ;
				spt_pkg::A_ER4K:  v = spt_pkg::V_ER4K;
				spt_pkg::A_RDSUP: v = spt_pkg::V_RDSUP;
				spt_pkg::A_RSV33: v = spt_pkg::V_FILL;
				spt_pkg::A_DEN0:  v = spt_pkg::V_FILL;
				spt_pkg::A_DEN1:  v = spt_pkg::V_FILL;
				spt_pkg::A_DEN2:  v = den;
				spt_pkg::A_DEN3:  v = spt_pkg::V_DEN3;
				spt_pkg::A_Q4WM:  v = spt_pkg::V_Q4WM;
				spt_pkg::A_Q4OP:  v = spt_pkg::V_Q4OP;
				spt_pkg::A_Q1WM:  v = spt_pkg::V_Q1WM;
				spt_pkg::A_Q1OP:  v = spt_pkg::V_Q1OP;
				spt_pkg::A_D1WM:  v = spt_pkg::V_D1WM;
				spt_pkg::A_D1OP:  v = spt_pkg::V_D1OP;
				spt_pkg::A_D2WM:  v = spt_pkg::V_D2WM;
				spt_pkg::A_D2OP:  v = spt_pkg::V_D2OP;
				default:          v = spt_pkg::V_FILL;
			endcase
		end
		return v;
	endfunction : byte_at

	// density variant select
	wire logic [7:0] den_byte =
		(den_sel_r == spt_pkg::DEN_2M)   ? spt_pkg::V_D2M   :
		(den_sel_r == spt_pkg::DEN_1M)   ? spt_pkg::V_D1M   :
		(den_sel_r == spt_pkg::DEN_512K) ? spt_pkg::V_D512K :
		(den_sel_r == spt_pkg::DEN_256K) ? spt_pkg::V_D256K :
		spt_pkg::V_D4M;

	// 64K opcode becomes 32K on the small parts and the uniform 1Mb
	wire logic small_part = (den_sel_r == spt_pkg::DEN_512K) ||
		(den_sel_r == spt_pkg::DEN_256K);
	wire logic uni_32k = small_part ||
		(opt_c_r && (den_sel_r == spt_pkg::DEN_1M));
	wire logic [1:0] er_kind_nxt =
		(op_code == spt_pkg::OP_ER4K)  ? spt_pkg::EK_4K  :
		(op_code == spt_pkg::OP_ER32K) ? spt_pkg::EK_32K :
		(op_code == spt_pkg::OP_ER64K) ? (uni_32k ? spt_pkg::EK_32K : spt_pkg::EK_64K) :
		spt_pkg::EK_NONE;

	// byte stream address
	wire logic [23:0] baddr_nxt = rd_start ? rd_addr : (baddr_r + 24'h000001);
	wire logic        b_step    = rd_start || (rd_next && bvld_r);
	wire logic        bvld_nxt  = rd_start || (bvld_r && !rd_stop);

	// AXI handshakes
	wire logic aw_hs = s_axi_awvalid && awready_r;
	wire logic w_hs  = s_axi_wvalid && wready_r;
	wire logic b_hs  = bvalid_r && s_axi_bready;
	wire logic ar_hs = s_axi_arvalid && arready_r;
	wire logic r_hs  = rvalid_r && s_axi_rready;
	wire logic wr_go = !awready_r && !wready_r && !bvalid_r;

	// write decode
	wire logic wr_cfg = (aw_addr_r == spt_pkg::R_CFG);
	wire logic wr_ro  = (aw_addr_r[31:6] == 26'h0) &&
		((aw_addr_r[5:4] == 2'b00) || (aw_addr_r[5:4] == 2'b11)) ||
		(aw_addr_r == spt_pkg::R_STAT);
	wire logic [1:0] bresp_nxt = wr_cfg ? spt_pkg::RESP_OK :
		(wr_ro ? spt_pkg::RESP_SLV : spt_pkg::RESP_DEC);

	// read decode
	wire logic ar_rom  = (s_axi_araddr[31:6] == 26'h0) &&
		((s_axi_araddr[5:4] == 2'b00) || (s_axi_araddr[5:4] == 2'b11));
	wire logic ar_cfg  = (s_axi_araddr == spt_pkg::R_CFG);
	wire logic ar_stat = (s_axi_araddr == spt_pkg::R_STAT);
	wire logic [31:0] cfg_word = {28'h0, opt_c_r, den_sel_r};
	wire logic [31:0] stat_word = {bvld_r, 7'h00, baddr_r};
	wire logic [31:0] rom_word;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			// lane g holds byte at word address plus g, low byte first
			assign rom_word[g*8 +: 8] = byte_at({16'h0000, s_axi_araddr[7:2], 2'(g)}, den_byte);
		end
	endgenerate

	wire logic [31:0] rdata_nxt = ar_rom ? rom_word :
		(ar_cfg ? cfg_word : (ar_stat ? stat_word : 32'h0000_0000));
	wire logic [1:0] rresp_nxt = (ar_rom || ar_cfg || ar_stat) ?
		spt_pkg::RESP_OK : spt_pkg::RESP_DEC;

	// write path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= spt_pkg::RESP_OK;
			aw_addr_r <= 32'h0000_0000;
			w_data_r  <= 32'h0000_0000;
			w_strb0_r <= 1'b0;
		end else if (aclk_en) begin
			if (aw_hs) begin
				awready_r <= 1'b0;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				wready_r  <= 1'b0;
				w_data_r  <= s_axi_wdata;
				w_strb0_r <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= bresp_nxt;
			end
			if (b_hs) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// configuration register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			den_sel_r <= spt_pkg::CFG_RST;
			opt_c_r   <= 1'b0;
		end else if (aclk_en && wr_go && wr_cfg && w_strb0_r) begin
			den_sel_r <= w_data_r[spt_pkg::CF_DEN +: 3];
			opt_c_r   <= w_data_r[spt_pkg::CF_OPTC];
		end
	end

	// read path, one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= spt_pkg::RESP_OK;
		end else if (aclk_en) begin
			if (ar_hs) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rdata_nxt;
				rresp_r   <= rresp_nxt;
			end else if (r_hs) begin
				arready_r <= 1'b1;
				rvalid_r  <= 1'b0;
			end
		end
	end

	// serial byte stream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			byte_r  <= spt_pkg::V_FILL;
			baddr_r <= 24'h000000;
			bvld_r  <= 1'b0;
		end else if (aclk_en) begin
			bvld_r <= bvld_nxt;
			if (b_step) begin
				baddr_r <= baddr_nxt;
				byte_r  <= byte_at(baddr_nxt, den_byte);
			end
		end
	end

	// erase opcode decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			er_vld_r  <= 1'b0;
			er_kind_r <= spt_pkg::EK_NONE;
		end else if (aclk_en) begin
			er_vld_r <= op_valid;
			if (op_valid) begin
				er_kind_r <= er_kind_nxt;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign rd_byte       = byte_r;
	assign rd_byte_addr  = baddr_r;
	assign rd_byte_valid = bvld_r;
	assign erase_valid   = er_vld_r;
	assign erase_kind    = er_kind_r;

	a_sig_first: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000000) |-> (byte_r == 8'h53))
		else $error("signature byte 0 wrong");
	a_hdr_idhi: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00000f) |-> (byte_r == 8'hff))
		else $error("header id high byte wrong");
	a_hdr_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000006) |-> (byte_r == 8'h00))
		else $error("header count wrong");
	a_tbl_len: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00000b) |-> (byte_r == 8'h10))
		else $error("table length wrong");
	a_tbl_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00000c) |-> (byte_r == 8'h30))
		else $error("table pointer wrong");
	a_erase_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000030) |-> (byte_r == 8'hed))
		else $error("erase size byte wrong");
	a_read_types: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000032) |-> (byte_r == 8'hf1))
		else $error("read support byte wrong");
	a_quad_op: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000039) |-> (byte_r == 8'heb))
		else $error("quad read opcode wrong");
	a_stream_order: assert property (@(posedge aclk) disable iff (!aresetn)
		(aclk_en && rd_next && bvld_r && !rd_start && !rd_stop)
		|=> (bvld_r && baddr_r == $past(baddr_r) + 24'h000001))
		else $error("stream address did not advance by one");
	a_erase_32k: assert property (@(posedge aclk) disable iff (!aresetn)
		(aclk_en && op_valid && (op_code == 8'h52 || (op_code == 8'hd8 && uni_32k)))
		|=> (erase_valid && erase_kind == 2'h2))
		else $error("32K erase not decoded");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(aclk_en && ar_hs) |=> (rvalid_r && !arready_r))
		else $error("read data not returned one cycle after address");
	a_sig_last: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000003) |-> (byte_r == 8'h50))
		else $error("signature byte 3 wrong");
	a_rev_major: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000005) |-> (byte_r == 8'h01))
		else $error("major revision byte wrong");
	a_hdr_idlo: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000008) |-> (byte_r == 8'h00))
		else $error("header id low byte wrong");
	a_hdr_minor: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000009) |-> (byte_r == 8'h06))
		else $error("header minor revision wrong");
	a_unused_fill: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000007) |-> (byte_r == 8'hff))
		else $error("unused header byte wrong");
	a_ptr_upper: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00000e) |-> (byte_r == 8'h00))
		else $error("table pointer upper byte wrong");
	a_erase_op: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000031) |-> (byte_r == 8'h20))
		else $error("4K erase opcode byte wrong");
	a_rsv_fill: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000033) |-> (byte_r == 8'hff))
		else $error("reserved byte 33h wrong");
	a_den_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000034) |-> (byte_r == 8'hff))
		else $error("density low byte wrong");
	a_den_top: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000037) |-> (byte_r == 8'h00))
		else $error("density top byte wrong");
	a_q4_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h000038) |-> (byte_r == 8'h44))
		else $error("quad io read cycles wrong");
	a_q1_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00003b) |-> (byte_r == 8'h6b))
		else $error("quad output read opcode wrong");
	a_d1_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00003c) |-> (byte_r == 8'h08))
		else $error("dual output read cycles wrong");
	a_d2_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00003e) |-> (byte_r == 8'h80))
		else $error("dual io read cycles wrong");
	a_d2_op: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvld_r && baddr_r == 24'h00003f) |-> (byte_r == 8'hbb))
		else $error("dual io read opcode wrong");
	a_stream_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(aclk_en && rd_stop && !rd_start) |=> !bvld_r)
		else $error("stream still open after stop");
	a_enable_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
		(!aclk_en) |=> ($stable(byte_r) && $stable(baddr_r) && $stable(bvld_r) && $stable(er_vld_r) &&
		$stable(er_kind_r) && $stable(den_sel_r) && $stable(rvalid_r) && $stable(bvalid_r)))
		else $error("state moved while clock enable low");

endmodule : spt_param_table
`default_nettype wire

// [logic/spt_pkg.sv]
/*
 * spt_pkg: constants of the discoverable-parameter table block:
 * database byte values, byte addresses, register offsets, field
 * positions, density variants and erase-kind codes.
 * Assumes nothing of its surroundings; shared by the design only.
 */
`default_nettype none
package spt_pkg;
	// database byte addresses
	localparam logic [7:0] A_SIG0  = 8'h00;
	localparam logic [7:0] A_SIG1  = 8'h01;
	localparam logic [7:0] A_SIG2  = 8'h02;
	localparam logic [7:0] A_SIG3  = 8'h03;
	localparam logic [7:0] A_REVMN = 8'h04;
	localparam logic [7:0] A_REVMJ = 8'h05;
	localparam logic [7:0] A_HCNT  = 8'h06;
	localparam logic [7:0] A_UNUSD = 8'h07;
	localparam logic [7:0] A_IDLO  = 8'h08;
	localparam logic [7:0] A_PMNR  = 8'h09;
	localparam logic [7:0] A_PMJR  = 8'h0a;
	localparam logic [7:0] A_PLEN  = 8'h0b;
	localparam logic [7:0] A_PTR0  = 8'h0c;
	localparam logic [7:0] A_PTR1  = 8'h0d;
	localparam logic [7:0] A_PTR2  = 8'h0e;
	localparam logic [7:0] A_IDHI  = 8'h0f;
	localparam logic [7:0] A_ERSZ  = 8'h30;
	localparam logic [7:0] A_ER4K  = 8'h31;
	localparam logic [7:0] A_RDSUP = 8'h32;
	localparam logic [7:0] A_RSV33 = 8'h33;
	localparam logic [7:0] A_DEN0  = 8'h34;
	localparam logic [7:0] A_DEN1  = 8'h35;
	localparam logic [7:0] A_DEN2  = 8'h36;
	localparam logic [7:0] A_DEN3  = 8'h37;
	localparam logic [7:0] A_Q4WM  = 8'h38;
	localparam logic [7:0] A_Q4OP  = 8'h39;
	localparam logic [7:0] A_Q1WM  = 8'h3a;
	localparam logic [7:0] A_Q1OP  = 8'h3b;
	localparam logic [7:0] A_D1WM  = 8'h3c;
	localparam logic [7:0] A_D1OP  = 8'h3d;
	localparam logic [7:0] A_D2WM  = 8'h3e;
	localparam logic [7:0] A_D2OP  = 8'h3f;
	// database byte values
	localparam logic [7:0] V_SIG0  = 8'h53;
	localparam logic [7:0] V_SIG1  = 8'h46;
	localparam logic [7:0] V_SIG2  = 8'h44;
	localparam logic [7:0] V_SIG3  = 8'h50;
	localparam logic [7:0] V_MINOR = 8'h06;
	localparam logic [7:0] V_MAJOR = 8'h01;
	localparam logic [7:0] V_HCNT  = 8'h00;
	localparam logic [7:0] V_FILL  = 8'hff;
	localparam logic [7:0] V_IDLO  = 8'h00;
	localparam logic [7:0] V_IDHI  = 8'hff;
	localparam logic [7:0] V_PLEN  = 8'h10;
	localparam logic [7:0] V_PTR0  = 8'h30;
	localparam logic [7:0] V_PTR1  = 8'h00;
	localparam logic [7:0] V_PTR2  = 8'h00;
	localparam logic [7:0] V_ERSZ  = {3'b111, 1'b0, 1'b1, 1'b1, 2'b01};
	localparam logic [7:0] V_ER4K  = 8'h20;
	localparam logic [7:0] V_RDSUP = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1};
	localparam logic [7:0] V_DEN3  = 8'h00;
	localparam logic [7:0] V_Q4WM  = {3'b010, 5'b00100};
	localparam logic [7:0] V_Q4OP  = 8'heb;
	localparam logic [7:0] V_Q1WM  = {3'b000, 5'b01000};
	localparam logic [7:0] V_Q1OP  = 8'h6b;
	localparam logic [7:0] V_D1WM  = {3'b000, 5'b01000};
	localparam logic [7:0] V_D1OP  = 8'h3b;
	localparam logic [7:0] V_D2WM  = {3'b100, 5'b00000};
	localparam logic [7:0] V_D2OP  = 8'hbb;
	// density byte at 36h per variant
	localparam logic [2:0] DEN_4M   = 3'h0;
	localparam logic [2:0] DEN_2M   = 3'h1;
	localparam logic [2:0] DEN_1M   = 3'h2;
	localparam logic [2:0] DEN_512K = 3'h3;
	localparam logic [2:0] DEN_256K = 3'h4;
	localparam logic [7:0] V_D4M    = 8'h3f;
	localparam logic [7:0] V_D2M    = 8'h1f;
	localparam logic [7:0] V_D1M    = 8'h0f;
	localparam logic [7:0] V_D512K  = 8'h07;
	localparam logic [7:0] V_D256K  = 8'h03;
	// erase opcodes and kinds
	localparam logic [7:0] OP_ER4K  = 8'h20;
	localparam logic [7:0] OP_ER32K = 8'h52;
	localparam logic [7:0] OP_ER64K = 8'hd8;
	localparam logic [1:0] EK_NONE  = 2'h0;
	localparam logic [1:0] EK_4K    = 2'h1;
	localparam logic [1:0] EK_32K   = 2'h2;
	localparam logic [1:0] EK_64K   = 2'h3;
	// register offsets and fields
	localparam logic [31:0] R_CFG   = 32'h0000_0040;
	localparam logic [31:0] R_STAT  = 32'h0000_0044;
	localparam int          CF_DEN  = 0;
	localparam int          CF_OPTC = 3;
	localparam int          ST_VLD  = 31;
	localparam logic [2:0] CFG_RST  = 3'h0;
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_SLV = 2'b10;
	localparam logic [1:0] RESP_DEC = 2'b11;
endpackage : spt_pkg
`default_nettype wire

// [dv/spt_host_model.sv]
/*
 * spt_host_model: serial front end stand-in that walks the parameter
 * database with byte-stream start, next and stop strobes.
 * Assumes it shares aclk with the table block.
 */
`default_nettype none
module spt_host_model (
	input  wire logic        aclk,
	output logic             rd_start,
	output logic [23:0]      rd_addr,
	output logic             rd_next,
	output logic             rd_stop
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rd_start = 1'b0;
		rd_addr  = 24'h000000;
		rd_next  = 1'b0;
		rd_stop  = 1'b0;
	end
	// one start, then n-1 back to back upward steps, then stop
	task automatic burst(input logic [23:0] a, input int n);
		int k;
		rd_start <= 1'b1;
		rd_addr  <= a;
		@(posedge aclk);
		rd_start <= 1'b0;
		rd_addr  <= ~a; // no longer qualified
		for (k = 1; k < n; k++) begin
			rd_next <= 1'b1;
			@(posedge aclk);
		end
		rd_next <= 1'b0;
		rd_stop <= 1'b1;
		@(posedge aclk);
		rd_stop <= 1'b0;
		@(posedge aclk);
	endtask : burst
	// step request while no stream is open
	task automatic nudge();
		rd_next <= 1'b1;
		@(posedge aclk);
		rd_next <= 1'b0;
		@(posedge aclk);
	endtask : nudge
endmodule : spt_host_model
`default_nettype wire

// [dv/spt_param_table_test.sv]
/*
 * spt_param_table_test: self-checking bench for the parameter table:
 * AXI4-Lite master, byte-stream host model and erase decode.
 * Assumes the package, the design and the host model compile first.
 */
`default_nettype none
module spt_param_table_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aclk_en, aresetn, stepped, op_valid, erase_valid, rd_byte_valid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rd_start, rd_next, rd_stop;
	logic [1:0]  s_axi_bresp, s_axi_rresp, erase_kind;
	logic [23:0] rd_addr, rd_byte_addr;
	logic [7:0]  rd_byte, op_code;
	logic [1:0]  bq[$], eq[$];
	logic [33:0] rq[$];
	logic [31:0] sq[$];
	logic [31:0] wexp[8];
	logic [7:0]  dv[6];
	logic [15:0] et[9];
	logic [2:0]  j;
	int          n_errors, checks, i;

	spt_param_table spt_param_table_i (
		.aclk, .aclk_en, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rd_start, .rd_addr, .rd_next,
		.rd_stop, .rd_byte, .rd_byte_addr, .rd_byte_valid, .op_valid, .op_code, .erase_valid, .erase_kind
	);
	spt_host_model spt_host_model_i (.aclk, .rd_start, .rd_addr, .rd_next, .rd_stop);

	always #5 aclk = ~aclk;

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic tmo();
		n_errors++;
		$display("wait limit ran out at %0t", $time);
		test_done();
	endtask : tmo

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		int n;
		bq.push_back(r);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 200) tmo();
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, input logic [33:0] e);
		int n;
		rq.push_back(e);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 200) tmo();
	endtask : axi_rd

	function automatic logic [7:0] db(input logic [7:0] a);
		if (a < 8'h10 || (a >= 8'h30 && a < 8'h40)) return 8'(wexp[{a[5], a[3:2]}] >> {a[1:0], 3'b000});
		return 8'hff;
	endfunction : db

	task automatic stream(input logic [7:0] a, input int n);
		int k;
		for (k = 0; k < n; k++) sq.push_back({16'h0000, a + 8'(k), db(a + 8'(k))});
		spt_host_model_i.burst({16'h0000, a}, n);
		check(34'(rd_byte_valid), 34'(0));
	endtask : stream

	task automatic erase(input logic [7:0] op, input logic [1:0] k);
		eq.push_back(k);
		op_code  <= op;
		op_valid <= 1'b1;
		@(posedge aclk);
		op_valid <= 1'b0;
		op_code  <= ~op;
		@(posedge aclk);
	endtask : erase

	// result watcher: oldest note against each answer
	always @(posedge aclk) begin
		stepped <= aresetn & aclk_en & (rd_start | (rd_next & rd_byte_valid));
		if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
		if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (erase_valid) check(34'(erase_kind), 34'(eq.pop_front()));
		if (stepped) check(34'({rd_byte_addr, rd_byte}), 34'(sq.pop_front()));
	end

	initial begin
		aclk = 1'b0;
		aclk_en = 1'b1;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, op_valid, op_code} = '0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		n_errors = 0;
		checks = 0;
		wexp = '{32'h50444653, 32'hff000106, 32'h10010600, 32'hff000030,
			32'hfff120ed, 32'h003fffff, 32'h6b08eb44, 32'hbb803b08};
		dv = '{8'h3f, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'h3f};
		et = '{16'h0201, 16'h0522, 16'h0d83, 16'h09f0, 16'h2d83, 16'had82, 16'ha522, 16'h3d82, 16'h4d82};
		void'($urandom(93));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(34'({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, rd_byte}), 34'(13'h1cff));
		$display("test reset done");
		for (i = 0; i < 16; i++) begin
			j = (i < 8) ? 3'(i) : 3'($urandom);
			axi_rd(32'({j[2], j[2], j[1:0], 2'b00}), {2'b00, wexp[j]});
		end
		$display("test database words done");
		axi_rd(32'h10, {2'b11, 32'h0});
		axi_rd(32'h2c, {2'b11, 32'h0});
		axi_wr(32'h00, 32'h12345678, 4'hf, 2'b10);
		axi_wr(32'h20, 32'h12345678, 4'hf, 2'b11);
		axi_rd(32'h00, {2'b00, wexp[0]});
		$display("test refused access done");
		stream(8'h00, 16);
		stream(8'h30, 16);
		stream(8'h0c, 8);
		axi_rd(32'h44, {2'b00, 32'h0000_0013});
		stream(8'h30 + 8'($urandom_range(15)), 1 + $urandom_range(15));
		spt_host_model_i.nudge();
		check(34'(rd_byte_valid), 34'(0));
		$display("test byte stream done");
		for (i = 0; i < 6; i++) begin
			axi_wr(32'h40, 32'(i), 4'h1, 2'b00);
			wexp[5] = {8'h00, dv[i], 16'hffff};
			axi_rd(32'h34, {2'b00, wexp[5]});
			stream(8'h34, 4);
		end
		axi_wr(32'h40, 32'h2, 4'h0, 2'b00);
		axi_rd(32'h34, {2'b00, wexp[5]});
		axi_rd(32'h40, {2'b00, 32'h0000_0005});
		$display("test density variants done");
		for (i = 0; i < 9; i++) begin
			axi_wr(32'h40, 32'(et[i][15:12]), 4'h1, 2'b00);
			erase(et[i][11:4], et[i][1:0]);
		end
		for (i = 0; i < 4; i++) begin
			erase(8'h80 + 8'($urandom_range(87)), 2'b00);
		end
		erase(8'h52, 2'b10);
		erase(8'h20, 2'b01);
		$display("test erase decode done");
		aclk_en  <= 1'b0;
		op_code  <= 8'h52;
		op_valid <= 1'b1;
		@(posedge aclk);
		op_valid <= 1'b0;
		repeat (2) @(posedge aclk);
		check(34'({erase_valid, erase_kind}), 34'(3'b001));
		aclk_en  <= 1'b1;
		aresetn  <= 1'b0;
		@(posedge aclk);
		aresetn  <= 1'b1;
		@(posedge aclk);
		axi_rd(32'h40, {2'b00, 32'h0000_0000});
		erase(8'hd8, 2'b11);
		$display("test enable and reset done");
		repeat (4) @(posedge aclk);
		check(34'(bq.size() + rq.size() + eq.size() + sq.size()), 34'(0));
		test_done();
	end
endmodule : spt_param_table_test
`default_nettype wire
